// ===== ptp_pkg.sv
// Notes on behaviour
// - inbound and outbound traffic are metered on separate bucket pairs
// - committed credit grows at the committed rate, capped at committed burst
// - enough committed credit gives green and spends it; else excess or drop
// - excess bucket fills at excess rate up to excess burst; sees only overflow
// - excess-evaluated packet over excess credit is dropped, otherwise yellow
// - red packets are always discarded, no further comparison
// - excess rate and burst both zero means single-rate two-color policing
// - two-rate three-color mode with conform and exceed actions is supported
// - committed rate in 40000 bps steps, 40000 up to 10000000000 bps
// - excess rate in 40000 bps steps, 0 up to 10000000000 bps
// - bursts take 1250 to 1250000000 bytes, one byte granularity
// - green packets optionally rewrite priority, traffic class and dscp
// - yellow packets optionally rewrite priority, traffic class and dscp
// - assigned traffic class is one of eight values, 0 to 7
// - actions may also rewrite the ip precedence bits
// - any color the packet already carries is ignored
// - committed burst below twice the frame size uses twice the frame size
// - unset burst is derived as 1.2 times rate over 8, in bytes
`default_nettype none
package ptp_pkg;
    localparam int CLK_HZ = 32'h05F5E100;
    localparam int RATE_STEP = 32'h00009C40;
    localparam int FRAC_W = 32'h18;
    localparam int RATE_W = 32'h12;
    localparam int BYTE_W = 32'h1F;
    localparam int LEN_W = 32'h10;
    localparam int CRED_W = BYTE_W + FRAC_W;
    // fractional bytes added per cycle for one rate step
    localparam logic [15:0] INC_PER_UNIT = 16'((64'(RATE_STEP) * (64'h1 << FRAC_W) / 64'h8
        + 64'(CLK_HZ / 2)) / 64'(CLK_HZ));
    // bytes of burst per rate step: 1.2 * step / 8
    localparam logic [12:0] BURST_PER_UNIT = 13'((RATE_STEP * 32'hC) / 32'h50);
    localparam logic [31:0] RATE_MAX = 32'h0003D090;
    localparam logic [31:0] BURST_MIN = 32'h000004E2;
    localparam logic [31:0] BURST_MAX = 32'h4A817C80;
    localparam int DIR_BIT = 32'h6;
    localparam logic [3:0] IDX_CIR = 4'h0;
    localparam logic [3:0] IDX_EIR = 4'h1;
    localparam logic [3:0] IDX_CBS = 4'h2;
    localparam logic [3:0] IDX_EBS = 4'h3;
    localparam logic [3:0] IDX_MTU = 4'h4;
    localparam logic [3:0] IDX_CACT = 4'h5;
    localparam logic [3:0] IDX_EACT = 4'h6;
    localparam logic [3:0] IDX_STAT = 4'h7;
    localparam logic [3:0] IDX_GREEN = 4'h8;
    localparam logic [3:0] IDX_YELLOW = 4'h9;
    localparam logic [3:0] IDX_RED = 4'hA;
    localparam int ACT_W = 32'h13;
    localparam int ACT_DSCP_LSB = 32'h0;
    localparam int ACT_DSCP_EN = 32'h6;
    localparam int ACT_PREC_LSB = 32'h7;
    localparam int ACT_PREC_EN = 32'hA;
    localparam int ACT_TC_LSB = 32'hB;
    localparam int ACT_TC_EN = 32'hE;
    localparam int ACT_PRI_LSB = 32'hF;
    localparam int ACT_PRI_EN = 32'h12;
    localparam logic [15:0] RST_MTU = 16'h05EE;
    localparam logic [RATE_W-1:0] RST_RATE = 18'h00000;
    localparam logic [BYTE_W-1:0] RST_BURST = 31'h00000000;
    localparam logic [ACT_W-1:0] RST_ACT = 19'h00000;
    typedef enum logic [1:0] {
        PTP_GREEN = 2'b00,
        PTP_YELLOW = 2'b01,
        PTP_RED = 2'b10
    } ptp_color_t;
endpackage
`default_nettype wire

// ===== ptp_bkt_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ptp_bkt_if;
    import ptp_pkg::*;
    logic load;
    logic take;
    logic ok;
    logic [RATE_W-1:0] rate;
    logic [BYTE_W-1:0] burst;
    logic [LEN_W-1:0] len;
    modport ctl (output load, take, rate, burst, len, input ok);
    modport bkt (input load, take, rate, burst, len, output ok);
endinterface
`default_nettype wire

// ===== ptp_bucket.sv
`timescale 1ns/1ns
`default_nettype none
module ptp_bucket
    import ptp_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    ptp_bkt_if.bkt bus
);
    logic [CRED_W-1:0] cred_r;
    logic [CRED_W-1:0] full;
    logic [CRED_W-1:0] inc;
    logic [CRED_W-1:0] need;
    logic [CRED_W:0] sum;
    logic [CRED_W-1:0] filled;

    assign full = CRED_W'({bus.burst, {FRAC_W{1'b0}}});
    assign inc = CRED_W'(bus.rate * INC_PER_UNIT);
    assign need = CRED_W'({bus.len, {FRAC_W{1'b0}}});
    assign sum = {1'b0, cred_r} + {1'b0, inc};
    assign filled = (sum > {1'b0, full}) ? full : sum[CRED_W-1:0];
    assign bus.ok = cred_r >= need;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cred_r <= '0;
        end else if (bus.load) begin
            cred_r <= full;
        end else if (bus.take) begin
            cred_r <= filled - need;
        end else begin
            cred_r <= filled;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_BKT_CAP: assert property (@(posedge i_mclk) disable iff (i_rst)
        !bus.load |-> cred_r <= full)
        else $error("bucket credit above burst");
    AST_BKT_LOAD: assert property (@(posedge i_mclk) disable iff (i_rst)
        bus.load |=> cred_r == $past(full))
        else $error("bucket not full after load");
    AST_BKT_FILL: assert property (@(posedge i_mclk) disable iff (i_rst)
        (!bus.load && !bus.take && {1'b0, cred_r} + {1'b0, inc} <= {1'b0, full})
        |=> cred_r == $past(cred_r) + $past(inc))
        else $error("bucket did not gain one tick of credit");
    AST_BKT_TAKE: assert property (@(posedge i_mclk) disable iff (i_rst)
        bus.take |-> bus.ok && !bus.load)
        else $error("credit taken without cover");
endmodule
`default_nettype wire

// ===== ptp_policer.sv
// Chosen here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
module ptp_policer
    import ptp_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic [1:0] i_pkt_valid,
    input wire logic [1:0][LEN_W-1:0] i_pkt_len,
    input wire logic [1:0][5:0] i_pkt_dscp,
    input wire logic [1:0][2:0] i_pkt_pri,
    input wire logic [1:0][2:0] i_pkt_tc,
    output logic [1:0] o_pkt_ready,
    output logic [1:0] o_res_valid,
    input wire logic [1:0] i_res_ready,
    output logic [1:0][1:0] o_res_color,
    output logic [1:0] o_res_drop,
    output logic [1:0][5:0] o_res_dscp,
    output logic [1:0][2:0] o_res_pri,
    output logic [1:0][2:0] o_res_tc
);
    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // returns {dscp, pri, tc} after the enabled rewrites
    function automatic logic [11:0] rewrite(input logic [ACT_W-1:0] act, input logic [5:0] dscp,
                                            input logic [2:0] pri, input logic [2:0] tc);
        logic [5:0] d;
        logic [2:0] p;
        logic [2:0] t;
        d = act[ACT_DSCP_EN] ? act[ACT_DSCP_LSB +: 6] : dscp;
        if (act[ACT_PREC_EN]) begin
            d[5:3] = act[ACT_PREC_LSB +: 3];
        end
        p = act[ACT_PRI_EN] ? act[ACT_PRI_LSB +: 3] : pri;
        t = act[ACT_TC_EN] ? act[ACT_TC_LSB +: 3] : tc;
        return {d, p, t};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [RATE_W-1:0] cir_r [2];
    logic [RATE_W-1:0] eir_r [2];
    logic [BYTE_W-1:0] cbs_r [2];
    logic [BYTE_W-1:0] ebs_r [2];
    logic [15:0] mtu_r [2];
    logic [ACT_W-1:0] cact_r [2];
    logic [ACT_W-1:0] eact_r [2];
    logic [31:0] cnt_r [2][3];
    logic [1:0] load_r;
    logic ack_r;
    logic [31:0] rdat_r;
    logic [1:0] res_valid_r;
    logic [1:0] drop_r;
    logic [1:0][1:0] color_r;
    logic [1:0][5:0] dscp_r;
    logic [1:0][2:0] pri_r;
    logic [1:0][2:0] tc_r;
    logic [1:0] take;
    logic [1:0] c_ok;
    logic [1:0] e_ok;
    logic [1:0] exc_en;
    logic [1:0] cfg_ok;
    logic [1:0][1:0] color_nxt;
    logic [BYTE_W-1:0] cbs_eff [2];
    logic [BYTE_W-1:0] ebs_eff [2];
    logic req;
    logic wdir;
    logic [3:0] widx;
    logic mapped;
    logic [31:0] cur;
    logic [31:0] wv;

    ptp_bkt_if bif [4] ();

    ////////////////////////////////////////////////////////////////////////
    // per direction metering
    genvar gd;
    generate
        for (gd = 0; gd < 2; gd++) begin : g_dir
            logic [BYTE_W-1:0] cder;
            logic [BYTE_W-1:0] twomtu;
            assign cder = (cbs_r[gd] == '0) ? BYTE_W'(cir_r[gd] * BURST_PER_UNIT) : cbs_r[gd];
            assign twomtu = BYTE_W'({mtu_r[gd], 1'b0});
            assign cbs_eff[gd] = (cder < twomtu) ? twomtu : cder;
            assign ebs_eff[gd] = (ebs_r[gd] == '0) ? BYTE_W'(eir_r[gd] * BURST_PER_UNIT) : ebs_r[gd];
            assign exc_en[gd] = (eir_r[gd] != '0) || (ebs_r[gd] != '0);
            assign cfg_ok[gd] = cir_r[gd] != '0;
            assign take[gd] = i_pkt_valid[gd] & o_pkt_ready[gd];
            assign o_pkt_ready[gd] = ~load_r[gd] & (~res_valid_r[gd] | i_res_ready[gd]);

            assign bif[2*gd].load = load_r[gd];
            assign bif[2*gd].rate = cir_r[gd];
            assign bif[2*gd].burst = cbs_eff[gd];
            assign bif[2*gd].len = i_pkt_len[gd];
            assign bif[2*gd].take = take[gd] & cfg_ok[gd] & c_ok[gd];
            assign c_ok[gd] = bif[2*gd].ok;

            assign bif[2*gd+1].load = load_r[gd];
            assign bif[2*gd+1].rate = eir_r[gd];
            assign bif[2*gd+1].burst = ebs_eff[gd];
            assign bif[2*gd+1].len = i_pkt_len[gd];
            assign bif[2*gd+1].take = take[gd] & cfg_ok[gd] & ~c_ok[gd] & exc_en[gd] & e_ok[gd];
            assign e_ok[gd] = bif[2*gd+1].ok;

            // three colors; over excess is red
            assign color_nxt[gd] = (!cfg_ok[gd] || c_ok[gd]) ? PTP_GREEN :
                                   (exc_en[gd] && e_ok[gd]) ? PTP_YELLOW : PTP_RED;

            ptp_bucket u_cbkt (
                .i_mclk(i_mclk),
                .i_rst(i_rst),
                .bus(bif[2*gd])
            );
            ptp_bucket u_ebkt (
                .i_mclk(i_mclk),
                .i_rst(i_rst),
                .bus(bif[2*gd+1])
            );

            AST_GREEN: assert property (@(posedge i_mclk) disable iff (i_rst)
                take[gd] && cfg_ok[gd] && c_ok[gd] |=> o_res_color[gd] == PTP_GREEN && !o_res_drop[gd])
                else $error("covered packet not green");
            AST_YELLOW: assert property (@(posedge i_mclk) disable iff (i_rst)
                take[gd] && cfg_ok[gd] && !c_ok[gd] && exc_en[gd] && e_ok[gd]
                |=> o_res_color[gd] == PTP_YELLOW)
                else $error("excess-covered packet not yellow");
            AST_TWO_COLOR: assert property (@(posedge i_mclk) disable iff (i_rst)
                take[gd] && cfg_ok[gd] && !c_ok[gd] && !exc_en[gd] |=> o_res_color[gd] == PTP_RED)
                else $error("single-rate overflow not red");
            AST_RED_DROP: assert property (@(posedge i_mclk) disable iff (i_rst)
                o_res_valid[gd] |-> o_res_drop[gd] == (o_res_color[gd] == PTP_RED))
                else $error("drop does not match red");
            AST_ONE_RESULT: assert property (@(posedge i_mclk) disable iff (i_rst)
                take[gd] |=> o_res_valid[gd] && o_res_dscp[gd] == $past(color_nxt[gd] == PTP_GREEN ?
                rewrite(cact_r[gd], i_pkt_dscp[gd], i_pkt_pri[gd], i_pkt_tc[gd]) >> 6 :
                color_nxt[gd] == PTP_YELLOW ?
                rewrite(eact_r[gd], i_pkt_dscp[gd], i_pkt_pri[gd], i_pkt_tc[gd]) >> 6 :
                12'(i_pkt_dscp[gd])))
                else $error("result missing or dscp wrong");
            AST_GREEN_TC: assert property (@(posedge i_mclk) disable iff (i_rst)
                take[gd] && color_nxt[gd] == PTP_GREEN && cact_r[gd][ACT_TC_EN]
                |=> o_res_tc[gd] == $past(cact_r[gd][ACT_TC_LSB +: 3]))
                else $error("conform class not applied");
            AST_YELLOW_PRI: assert property (@(posedge i_mclk) disable iff (i_rst)
                take[gd] && color_nxt[gd] == PTP_YELLOW && eact_r[gd][ACT_PRI_EN]
                |=> o_res_pri[gd] == $past(eact_r[gd][ACT_PRI_LSB +: 3]))
                else $error("exceed priority not applied");
            AST_BURST_FLOOR: assert property (@(posedge i_mclk) disable iff (i_rst)
                cbs_eff[gd] >= BYTE_W'({mtu_r[gd], 1'b0}))
                else $error("committed burst below two frames");
            AST_HOLD: assert property (@(posedge i_mclk) disable iff (i_rst)
                o_res_valid[gd] && !i_res_ready[gd] |=> o_res_valid[gd] && $stable(o_res_color[gd]))
                else $error("stalled result changed");
            CVR_GREEN: cover property (@(posedge i_mclk) take[gd] && color_nxt[gd] == PTP_GREEN);
            CVR_YELLOW: cover property (@(posedge i_mclk) take[gd] && color_nxt[gd] == PTP_YELLOW);
            CVR_RED: cover property (@(posedge i_mclk) take[gd] && color_nxt[gd] == PTP_RED);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // results
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            res_valid_r <= '0;
            drop_r <= '0;
            color_r <= '0;
            dscp_r <= '0;
            pri_r <= '0;
            tc_r <= '0;
        end else begin
            for (int d = 0; d < 2; d++) begin
                if (take[d]) begin
                    res_valid_r[d] <= 1'b1;
                    color_r[d] <= color_nxt[d];
                    drop_r[d] <= color_nxt[d] == PTP_RED;
                    if (color_nxt[d] == PTP_GREEN) begin
                        {dscp_r[d], pri_r[d], tc_r[d]} <=
                            rewrite(cact_r[d], i_pkt_dscp[d], i_pkt_pri[d], i_pkt_tc[d]);
                    end else if (color_nxt[d] == PTP_YELLOW) begin
                        {dscp_r[d], pri_r[d], tc_r[d]} <=
                            rewrite(eact_r[d], i_pkt_dscp[d], i_pkt_pri[d], i_pkt_tc[d]);
                    end else begin
                        {dscp_r[d], pri_r[d], tc_r[d]} <= {i_pkt_dscp[d], i_pkt_pri[d], i_pkt_tc[d]};
                    end
                end else if (i_res_ready[d]) begin
                    res_valid_r[d] <= 1'b0;
                end
            end
        end
    end

    assign o_res_valid = res_valid_r;
    assign o_res_color = color_r;
    assign o_res_drop = drop_r;
    assign o_res_dscp = dscp_r;
    assign o_res_pri = pri_r;
    assign o_res_tc = tc_r;

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave
    assign req = i_wb_cyc & i_wb_stb & ~ack_r;
    assign wdir = i_wb_adr[DIR_BIT];
    assign widx = i_wb_adr[5:2];
    assign mapped = ~i_wb_adr[7] & (i_wb_adr[1:0] == 2'h0) & (widx <= IDX_RED);
    assign wv = merge(cur, i_wb_dat, i_wb_sel);

    always_comb begin
        cur = '0;
        if (mapped) begin
            case (widx)
                IDX_CIR: cur = 32'(cir_r[wdir]);
                IDX_EIR: cur = 32'(eir_r[wdir]);
                IDX_CBS: cur = 32'(cbs_r[wdir]);
                IDX_EBS: cur = 32'(ebs_r[wdir]);
                IDX_MTU: cur = 32'(mtu_r[wdir]);
                IDX_CACT: cur = 32'(cact_r[wdir]);
                IDX_EACT: cur = 32'(eact_r[wdir]);
                IDX_STAT: cur = {29'h0, res_valid_r[wdir], exc_en[wdir], cfg_ok[wdir]};
                IDX_GREEN: cur = cnt_r[wdir][0];
                IDX_YELLOW: cur = cnt_r[wdir][1];
                IDX_RED: cur = cnt_r[wdir][2];
                default: cur = '0;
            endcase
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ack_r <= 1'b0;
            rdat_r <= '0;
        end else begin
            ack_r <= req;
            rdat_r <= req ? cur : '0;
        end
    end

    assign o_wb_ack = ack_r;
    assign o_wb_dat = rdat_r;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            for (int d = 0; d < 2; d++) begin
                cir_r[d] <= RST_RATE;
                eir_r[d] <= RST_RATE;
                cbs_r[d] <= RST_BURST;
                ebs_r[d] <= RST_BURST;
                mtu_r[d] <= RST_MTU;
                cact_r[d] <= RST_ACT;
                eact_r[d] <= RST_ACT;
            end
        end else if (req && i_wb_we && mapped) begin
            case (widx)
                IDX_CIR: if (wv != '0 && wv <= RATE_MAX) cir_r[wdir] <= RATE_W'(wv);
                IDX_EIR: if (wv <= RATE_MAX) eir_r[wdir] <= RATE_W'(wv);
                IDX_CBS: if (wv == '0 || (wv >= BURST_MIN && wv <= BURST_MAX)) cbs_r[wdir] <= BYTE_W'(wv);
                IDX_EBS: if (wv == '0 || (wv >= BURST_MIN && wv <= BURST_MAX)) ebs_r[wdir] <= BYTE_W'(wv);
                IDX_MTU: mtu_r[wdir] <= wv[15:0];
                IDX_CACT: cact_r[wdir] <= ACT_W'(wv);
                IDX_EACT: eact_r[wdir] <= ACT_W'(wv);
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            load_r <= 2'h3;
        end else begin
            load_r <= 2'h0;
            if (req && i_wb_we && mapped && widx <= IDX_MTU) begin
                load_r[wdir] <= 1'b1;
            end
        end
    end

    // color counters; count beats clear
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            for (int d = 0; d < 2; d++) begin
                for (int c = 0; c < 3; c++) begin
                    cnt_r[d][c] <= '0;
                end
            end
        end else begin
            for (int d = 0; d < 2; d++) begin
                for (int c = 0; c < 3; c++) begin
                    if (req && i_wb_we && mapped && wdir == d[0] && widx == IDX_GREEN + 4'(c)) begin
                        cnt_r[d][c] <= 32'(take[d] && color_nxt[d] == 2'(c));
                    end else if (take[d] && color_nxt[d] == 2'(c)) begin
                        cnt_r[d][c] <= cnt_r[d][c] + 32'h1;
                    end
                end
            end
        end
    end

    AST_WB_ACK: assert property (@(posedge i_mclk) disable iff (i_rst)
        req |=> o_wb_ack ##1 !o_wb_ack)
        else $error("wishbone ack not single cycle");
    CVR_WB_WRITE: cover property (@(posedge i_mclk) o_wb_ack && i_wb_we);
endmodule
`default_nettype wire

// ===== ptp_sink.sv
`timescale 1ns/1ns
`default_nettype none
module ptp_sink (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_stall,
    input wire logic [1:0] i_res_valid,
    output logic [1:0] o_res_ready,
    output logic [1:0] o_got
);
    logic phase_r;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            phase_r <= 1'b0;
        end else begin
            phase_r <= ~phase_r;
        end
    end
    assign o_res_ready = i_stall ? {2{phase_r}} : 2'h3;
    assign o_got = i_res_valid & o_res_ready;
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import ptp_pkg::*;
    localparam logic [14:0] G_PLAIN = {2'b00, 1'b0, 6'h0A, 3'h2, 3'h1};
    localparam logic [14:0] G_ACT = {2'b00, 1'b0, 6'h0A, 3'h7, 3'h5};
    localparam logic [14:0] Y_ACT = {2'b01, 1'b0, 6'h35, 3'h2, 3'h1};
    localparam logic [14:0] RED = {2'b10, 1'b1, 6'h0A, 3'h2, 3'h1};
    logic i_mclk = 1'b0, i_rst = 1'b1, cyc = 1'b0, we = 1'b0, stall = 1'b0, ack;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, o_dat;
    logic [1:0] pv = 2'h0, prdy, rv, rrdy, got, rdrop;
    logic [1:0][LEN_W-1:0] plen = '0;
    logic [1:0][5:0] pdscp = '0, rdscp;
    logic [1:0][2:0] ppri = '0, ptc = '0, rpri, rtc;
    logic [1:0][1:0] rcol;
    int error_cnt = 0, comparisons = 0;
    ptp_policer u_ptp_policer (.i_mclk(i_mclk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(o_dat), .o_wb_ack(ack), .i_pkt_valid(pv),
        .i_pkt_len(plen), .i_pkt_dscp(pdscp), .i_pkt_pri(ppri), .i_pkt_tc(ptc), .o_pkt_ready(prdy),
        .o_res_valid(rv), .i_res_ready(rrdy), .o_res_color(rcol), .o_res_drop(rdrop), .o_res_dscp(rdscp),
        .o_res_pri(rpri), .o_res_tc(rtc));
    ptp_sink u_ptp_sink (.i_mclk(i_mclk), .i_rst(i_rst), .i_stall(stall), .i_res_valid(rv),
        .o_res_ready(rrdy), .o_got(got));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do @(posedge i_mclk); while (ack !== 1'b1);
        rdat = o_dat;
        cyc <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
    endtask
    task automatic pkt(input int d, input logic [15:0] len, input logic [14:0] exp);
        @(posedge i_mclk);
        pv[d] <= 1'b1;
        plen[d] <= len;
        pdscp[d] <= 6'h0A;
        ppri[d] <= 3'h2;
        ptc[d] <= 3'h1;
        do @(posedge i_mclk); while (prdy[d] !== 1'b1);
        pv[d] <= 1'b0;
        plen[d] <= ~len;
        do @(posedge i_mclk); while (got[d] !== 1'b1);
        chk({17'h0, rcol[d], rdrop[d], rdscp[d], rpri[d], rtc[d]}, {17'h0, exp});
    endtask
    task automatic finish_test;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        forever #5 i_mclk = ~i_mclk;
    end
    initial begin
        #300000;
        error_cnt++;
        finish_test();
    end
    initial begin
        repeat (6) @(posedge i_mclk);
        i_rst <= 1'b0;
        wb(1'b0, 8'h10, 32'h0);
        chk(rdat, 32'h000005EE);
        wb(1'b0, 8'h00, 32'h0);
        chk(rdat, 32'h0);
        wb(1'b0, 8'h80, 32'h0);
        chk(rdat, 32'h0);
        // inbound: small burst, frame size raises it
        wb(1'b1, 8'h10, 32'h000003E8);
        wb(1'b1, 8'h08, 32'h000004E2);
        wb(1'b1, 8'h14, 32'h0007E800);
        wb(1'b1, 8'h18, 32'h00000755);
        // one rate step, far below any port bandwidth
        wb(1'b1, 8'h00, 32'h00000001);
        pkt(0, 16'h03E8, G_ACT);
        pkt(0, 16'h03E8, G_ACT);
        pkt(0, 16'h03E8, RED);
        wb(1'b0, 8'h1C, 32'h0);
        chk(rdat, 32'h00000001);
        // excess burst enables the second bucket
        stall <= 1'b1;
        wb(1'b1, 8'h0C, 32'h000004E2);
        pkt(0, 16'h03E8, G_ACT);
        pkt(0, 16'h03E8, G_ACT);
        pkt(0, 16'h03E8, Y_ACT);
        pkt(0, 16'h03E8, RED);
        // outbound has no committed rate set and passes green unmetered
        pkt(1, 16'hFFFF, G_PLAIN);
        wb(1'b0, 8'h20, 32'h0);
        chk(rdat, 32'h00000004);
        wb(1'b0, 8'h24, 32'h0);
        chk(rdat, 32'h00000001);
        wb(1'b0, 8'h28, 32'h0);
        chk(rdat, 32'h00000002);
        wb(1'b0, 8'h60, 32'h0);
        chk(rdat, 32'h00000001);
        // zero committed rate refused
        wb(1'b1, 8'h00, 32'h0);
        wb(1'b0, 8'h00, 32'h0);
        chk(rdat, 32'h00000001);
        // out-of-range settings refused
        wb(1'b1, 8'h00, 32'h0003D091);
        wb(1'b0, 8'h00, 32'h0);
        chk(rdat, 32'h00000001);
        wb(1'b1, 8'h04, 32'h0003D091);
        wb(1'b0, 8'h04, 32'h0);
        chk(rdat, 32'h0);
        wb(1'b1, 8'h08, 32'h000004E1);
        wb(1'b0, 8'h08, 32'h0);
        chk(rdat, 32'h000004E2);
        finish_test();
    end
endmodule
`default_nettype wire
